// ---- rtl/bsf_pkg.sv ----
// Purpose: shared constants for the boot-sector flash host controller
// Assumes: 40 MHz ref_clk, asynchronous parallel NOR flash on the pins
// Notes:   command codes and timing figures are plain defaults
//
// Behaviour
// RL1 - word mode uses all sixteen data pins, byte mode only the low eight
// RL2 - array holds 2,097,152 bytes or 1,048,576 words
// RL3 - chip select, write strobe and output strobe are separate active-low controls
// RL4 - every command write cycle presents address and data for the device to latch
// RL5 - program sequence completion starts the device's own program algorithm
// RL6 - unlock-bypass program needs two write cycles instead of four
// RL7 - erase sequence starts the device's own preprogram and erase algorithm
// RL8 - progress shown on ready/busy pin, data-polling bit and toggle bit
// RL9 - after program or erase, device returns to array read and takes commands
// RL10 - sector erase leaves other sectors intact; full-chip erase is supported
// RL11 - byte-mode sectors: 16K, two 8K, 32K, thirty-one 64K; boot top or bottom
// RL12 - program and erase into protected sectors are rejected
// RL13 - erase may be suspended for reads and programs elsewhere, then resumed; the host takes BSF_OP_SUSPEND only once an erase has finished
// RL14 - hardware reset aborts any operation and returns device to array read
// RL15 - device sleeps when addresses stay still; host may force standby
// RL16 - host waits for completion before the next command, except erase suspend; op_ready stays low through an erase, so suspend waits too
package bsf_pkg;
  localparam int ADDR_W      = 21;               // byte addresses of 2,097,152
  localparam int DATA_W      = 16;
  localparam int BYTE_DEPTH  = 2097152;
  localparam int WORD_DEPTH  = 1048576;
  // bus cycle timing
  localparam int CLK_NS      = 25;
  localparam int ACCESS_NS   = 120;              // slowest access grade
  localparam int STROBE_NS   = 50;
  localparam int RESET_NS    = 500;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC   = (RESET_NS + CLK_NS - 1) / CLK_NS;
  // unlock sequence, default command set
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
  localparam logic [7:0]  CMD_BYPASS   = 8'h20;
  localparam logic [7:0]  CMD_BYP_EXIT = 8'h90;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  // status bit positions
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  // host operations
  typedef enum logic [3:0] {
    BSF_OP_READ, BSF_OP_PROGRAM, BSF_OP_SECTOR_ERASE, BSF_OP_CHIP_ERASE,
    BSF_OP_SUSPEND, BSF_OP_RESUME, BSF_OP_BYPASS_ENTER, BSF_OP_BYPASS_EXIT,
    BSF_OP_RESET_CMD, BSF_OP_HW_RESET, BSF_OP_STANDBY
  } bsf_op_t;
endpackage

// ---- rtl/bsf_cyc_if.sv ----
// Purpose: one bus cycle request between sequencer and pin cycle engine
// Assumes: single clock ref_clk
// Notes:   req held until done pulses
`timescale 1ns/1ps
`default_nettype none
interface bsf_cyc_if;
  logic        req;
  logic        wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output done, output rdata);
endinterface
`default_nettype wire

// ---- rtl/bsf_cycle.sv ----
// Purpose: drives one read or write cycle on the flash pins
// Assumes: data_pins_i already synchronised by the caller
// Notes:   strobes separated from chip select to avoid contention
`timescale 1ns/1ps
`default_nettype none
module bsf_cycle
  import bsf_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   arst_n,
  bsf_cyc_if.eng      cyc,
  input  wire logic   word_mode,
  input  wire logic [15:0] data_pins_i,
  output logic [20:0] addr_o,
  output logic [15:0] data_pins_o,
  output logic [15:0] data_pins_oe,
  output logic        chip_sel_n,
  output logic        write_strb_n,
  output logic        out_strb_n
);
  import bsf_pkg::*;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_DONE} bsf_cst_t;
  bsf_cst_t   st;
  logic [3:0] cnt;
  logic       is_wr;

  // ----------------------------------------
  // cycle sequencing
  // ----------------------------------------
  // chip select first, then one strobe at a time
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st           <= C_IDLE;
      cnt          <= 4'h0;
      is_wr        <= 1'b0;
      addr_o       <= 21'h00_0000;
      data_pins_o  <= 16'h0000;
      data_pins_oe <= 16'h0000;
      chip_sel_n   <= 1'b1;
      write_strb_n <= 1'b1;
      out_strb_n   <= 1'b1;
      cyc.rdata    <= 16'h0000;
    end else begin
      unique case (st)
        C_IDLE: begin
          if (cyc.req) begin
            is_wr       <= cyc.wr;
            addr_o      <= cyc.addr;                       // RL4
            data_pins_o <= cyc.wdata;
            data_pins_oe <= cyc.wr ? (word_mode ? 16'hffff : 16'h00ff)
                                   : 16'h0000;              // RL1
            chip_sel_n  <= 1'b0;                             // RL3
            st          <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (is_wr) write_strb_n <= 1'b0;                   // RL3
          else       out_strb_n   <= 1'b0;
          cnt <= 4'(is_wr ? STROBE_CYC : ACCESS_CYC);
          st  <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt == 4'h1) begin
            if (!is_wr)
              cyc.rdata <= word_mode ? data_pins_i
                                     : {8'h00, data_pins_i[7:0]}; // RL1
            write_strb_n <= 1'b1;
            out_strb_n   <= 1'b1;
            st           <= C_DONE;
          end
          cnt <= cnt - 4'h1;
        end
        C_DONE: begin
          chip_sel_n   <= 1'b1;
          data_pins_oe <= 16'h0000;  // release after strobe, hold time kept
          st           <= C_IDLE;
        end
      endcase
    end
  end

  assign cyc.done = (st == C_DONE);
endmodule
`default_nettype wire

// ---- rtl/bsf_host.sv ----
// Purpose: host controller issuing read, program and erase to a NOR flash
// Assumes: flash pins asynchronous to ref_clk; all pin inputs synchronised
// Notes:   one operation at a time, busy until the flash reports completion
`timescale 1ns/1ps
`default_nettype none
module bsf_host
  import bsf_pkg::*;
#(
  parameter int POLL_LIMIT = 1000000  // status reads before timeout
)(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // user side
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire bsf_pkg::bsf_op_t op_code,
  input  wire logic [20:0] op_addr,
  input  wire logic [15:0] op_wdata,
  input  wire logic        word_mode,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_error,
  output logic             bypass_active,
  output logic             erase_suspended,
  // flash pins
  output logic [20:0]      addr_o,
  input  wire logic [15:0] data_pins_i,
  output logic [15:0]      data_pins_o,
  output logic [15:0]      data_pins_oe,
  output logic             chip_sel_n,
  output logic             write_strb_n,
  output logic             out_strb_n,
  output logic             word_mode_n,
  output logic             hw_reset_n,
  input  wire logic        ready_busy_n_pin
);
  import bsf_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [15:0] dq_s1, dq_s2;
  logic        rb_s1, rb_s2;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= data_pins_i;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_n_pin;
      rb_s2 <= rb_s1;
    end
  end

  bsf_cyc_if cyc ();
  logic      chip_sel_n_c;

  bsf_cycle u_cycle (
    .ref_clk      (ref_clk),
    .arst_n       (arst_n),
    .cyc          (cyc.eng),
    .word_mode    (word_mode),
    .data_pins_i  (dq_s2),
    .addr_o       (addr_o),
    .data_pins_o  (data_pins_o),
    .data_pins_oe (data_pins_oe),
    .chip_sel_n   (chip_sel_n_c),
    .write_strb_n (write_strb_n),
    .out_strb_n   (out_strb_n)
  );

  typedef enum logic [2:0] {S_IDLE, S_CYC, S_POLL, S_CHECK, S_RESET, S_RESP}
    bsf_st_t;
  bsf_st_t     st;
  bsf_op_t     op;
  logic [20:0] a;
  logic [15:0] wd;
  logic [2:0]  step, nsteps;
  logic        poll_prev_valid;
  logic [15:0] poll_prev;
  logic [31:0] poll_cnt;
  logic [7:0]  rst_cnt;
  logic        standby;

  // command address, scaled to byte address in byte mode
  function automatic logic [20:0] cmd_addr(input logic [11:0] w, input logic wm);
    cmd_addr = wm ? {9'h000, w} : {8'h00, w, 1'b0};
  endfunction

  // ----------------------------------------
  // write cycle table for each operation
  // ----------------------------------------
  logic [20:0] cyc_addr;
  logic [15:0] cyc_data;
  logic        cyc_wr;
  logic        unlock_now;
  logic        erase_pair;
  always_comb begin
    cyc_addr   = a;
    cyc_data   = wd;
    cyc_wr     = 1'b1;
    unlock_now = !(bypass_active && op == BSF_OP_PROGRAM);
    nsteps     = 3'd1;
    unique case (op)
      BSF_OP_READ: begin
        cyc_wr = 1'b0;
      end
      BSF_OP_PROGRAM: begin
        nsteps = bypass_active ? 3'd2 : 3'd4;                      // RL6
      end
      BSF_OP_SECTOR_ERASE, BSF_OP_CHIP_ERASE: begin
        nsteps = 3'd6;                                             // RL7 RL10
      end
      BSF_OP_BYPASS_ENTER: begin
        nsteps = 3'd3;
      end
      BSF_OP_BYPASS_EXIT: begin
        nsteps = 3'd2;
      end
      default: begin
        nsteps = 3'd1;
      end
    endcase
    // unlock pair sits at steps 0,1 and again 3,4 for erase only;
    // program step 3 must carry the user data, not a second unlock
    erase_pair = (nsteps == 3'd6);
    if (unlock_now && nsteps > 3'd2 && (step == 3'd0 || (erase_pair && step == 3'd3))) begin
      cyc_addr = cmd_addr(UNLOCK_ADDR1, word_mode);
      cyc_data = {8'h00, UNLOCK_DATA1};
    end else if (unlock_now && nsteps > 3'd2 &&
                 (step == 3'd1 || (erase_pair && step == 3'd4))) begin
      cyc_addr = cmd_addr(UNLOCK_ADDR2, word_mode);
      cyc_data = {8'h00, UNLOCK_DATA2};
    end else if (step == 3'd2 || (!unlock_now && step == 3'd0) ||
                 (op == BSF_OP_BYPASS_EXIT && step == 3'd0)) begin
      cyc_addr = cmd_addr(UNLOCK_ADDR1, word_mode);
      unique case (op)
        BSF_OP_PROGRAM:      cyc_data = {8'h00, CMD_PROGRAM};      // RL5
        BSF_OP_BYPASS_ENTER: cyc_data = {8'h00, CMD_BYPASS};
        BSF_OP_BYPASS_EXIT:  cyc_data = {8'h00, CMD_BYP_EXIT};
        default:             cyc_data = {8'h00, CMD_ERASE};
      endcase
    end else if (op == BSF_OP_BYPASS_EXIT) begin
      cyc_data = 16'h0000;
    end else if (op == BSF_OP_CHIP_ERASE) begin
      cyc_addr = cmd_addr(UNLOCK_ADDR1, word_mode);
      cyc_data = {8'h00, CMD_CHIP};
    end else if (op == BSF_OP_SECTOR_ERASE) begin
      cyc_data = {8'h00, CMD_SECTOR};                              // RL11 sector address
    end else if (op == BSF_OP_SUSPEND) begin
      cyc_data = {8'h00, CMD_SUSPEND};                             // RL13
    end else if (op == BSF_OP_RESUME) begin
      cyc_data = {8'h00, CMD_RESUME};                              // RL13
    end else if (op == BSF_OP_RESET_CMD) begin
      cyc_data = {8'h00, CMD_RESET};
    end
  end

  assign cyc.req   = (st == S_CYC) || (st == S_POLL);
  assign cyc.wr    = (st == S_CYC) && cyc_wr;
  assign cyc.addr  = cyc_addr;
  assign cyc.wdata = cyc_data;
  // standby: chip select held inactive while the host parks the device
  assign chip_sel_n = chip_sel_n_c | standby;                      // RL15
  assign op_ready   = (st == S_IDLE);                              // RL16
  assign word_mode_n = ~word_mode;                                 // RL1

  wire embedded = (op == BSF_OP_PROGRAM || op == BSF_OP_SECTOR_ERASE ||
                   op == BSF_OP_CHIP_ERASE || op == BSF_OP_RESUME);
  // busy if toggle bit changes between two reads or ready/busy low
  wire toggling = poll_prev_valid &&
                  (poll_prev[TOGGLE_BIT] != cyc.rdata[TOGGLE_BIT]);

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st              <= S_IDLE;
      op              <= BSF_OP_READ;
      a               <= 21'h00_0000;
      wd              <= 16'h0000;
      step            <= 3'd0;
      poll_prev_valid <= 1'b0;
      poll_prev       <= 16'h0000;
      poll_cnt        <= 32'h0000_0000;
      rst_cnt         <= 8'h00;
      rsp_valid       <= 1'b0;
      rsp_rdata       <= 16'h0000;
      rsp_error       <= 1'b0;
      bypass_active   <= 1'b0;
      erase_suspended <= 1'b0;
      hw_reset_n      <= 1'b1;
      standby         <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st)
        S_IDLE: begin
          if (op_valid) begin
            op   <= op_code;
            a    <= op_addr;
            wd   <= op_wdata;
            step <= 3'd0;
            rsp_error <= 1'b0;
            if (op_code == BSF_OP_HW_RESET) begin
              hw_reset_n <= 1'b0;                                  // RL14
              rst_cnt    <= 8'(RESET_CYC);
              st         <= S_RESET;
            end else if (op_code == BSF_OP_STANDBY) begin
              standby <= 1'b1;                                     // RL15
              st      <= S_RESP;
            end else begin
              standby <= 1'b0;
              st      <= S_CYC;
            end
          end
        end
        S_CYC: begin
          if (cyc.done) begin
            if (step + 3'd1 < nsteps) begin
              step <= step + 3'd1;
            end else begin
              rsp_rdata <= cyc.rdata;
              if (op == BSF_OP_BYPASS_ENTER) bypass_active <= 1'b1;
              if (op == BSF_OP_BYPASS_EXIT)  bypass_active <= 1'b0;
              if (op == BSF_OP_SUSPEND)      erase_suspended <= 1'b1;
              if (op == BSF_OP_RESUME)       erase_suspended <= 1'b0;
              poll_prev_valid <= 1'b0;
              poll_cnt        <= 32'h0000_0000;
              st <= (embedded || op == BSF_OP_SUSPEND) ? S_POLL : S_RESP;
            end
          end
        end
        S_POLL: begin
          if (cyc.done) begin
            // keep the older read so the check sees two distinct samples
            if (!poll_prev_valid) poll_prev <= cyc.rdata;
            poll_prev_valid <= 1'b1;
            poll_cnt        <= poll_cnt + 32'h1;
            if (poll_prev_valid) st <= S_CHECK;
          end
        end
        S_CHECK: begin
          // done when toggle stops and ready/busy is high
          if (!toggling && rb_s2) begin                            // RL8 RL9
            // program that finished: polling bit must equal written data
            rsp_error <= (op == BSF_OP_PROGRAM) &&
                         (cyc.rdata[POLL_BIT] != wd[POLL_BIT]);    // RL12
            st <= S_RESP;
          end else if (op == BSF_OP_SUSPEND && !toggling) begin
            st <= S_RESP;                     // suspended erase keeps ready/busy low
          end else if (poll_cnt >= 32'(POLL_LIMIT)) begin
            rsp_error <= 1'b1;                // rejected or stuck, give up
            st        <= S_RESP;
          end else begin
            poll_prev <= cyc.rdata;
            st        <= S_POLL;
          end
        end
        S_RESET: begin
          rst_cnt <= rst_cnt - 8'h01;
          if (rst_cnt == 8'h01) begin
            hw_reset_n      <= 1'b1;
            bypass_active   <= 1'b0;                               // RL14
            erase_suspended <= 1'b0;
            st              <= S_RESP;
          end
        end
        S_RESP: begin
          rsp_valid <= 1'b1;
          st        <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- sim/bsf_host_props.sv ----
// Purpose: pin and handshake checks on the flash host controller
// Assumes: one clock domain, ref_clk, reset arst_n
// Notes:   strobe lengths follow the cycle engine's fixed counts
`timescale 1ns/1ps
`default_nettype none
module bsf_host_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic        word_mode,
  input wire logic        rsp_valid,
  input wire logic [20:0] addr_o,
  input wire logic [15:0] data_pins_o,
  input wire logic [15:0] data_pins_oe,
  input wire logic        chip_sel_n,
  input wire logic        write_strb_n,
  input wire logic        out_strb_n,
  input wire logic        word_mode_n,
  input wire logic        hw_reset_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // bus cycle shape and handshake
  // ----------------------------------------
  strobe_apart_a: assert property (
    !write_strb_n |-> !chip_sel_n && out_strb_n)
    else $error("write strobe without select or with read strobe");
  read_no_drive_a: assert property (
    !out_strb_n |-> !chip_sel_n && data_pins_oe == 16'h0)
    else $error("read strobe while driving data pins");
  byte_lanes_a: assert property (
    !word_mode |-> data_pins_oe[15:8] == 8'h00)
    else $error("upper data pins driven in byte mode");
  width_pin_a: assert property (
    word_mode_n == !word_mode)
    else $error("width pin does not follow word mode");
  wr_pulse_a: assert property (
    $fell(write_strb_n) |-> !write_strb_n [*2] ##1 write_strb_n)
    else $error("write strobe not two cycles low");
  wr_hold_a: assert property (
    !write_strb_n && $past(!write_strb_n) |-> $stable(addr_o) && $stable(data_pins_o))
    else $error("address or data moved during write strobe");
  rd_pulse_a: assert property (
    $fell(out_strb_n) |-> !out_strb_n [*5] ##1 out_strb_n)
    else $error("read strobe not five cycles low");
  accept_busy_a: assert property (
    op_valid && op_ready |=> !op_ready)
    else $error("still ready after taking a request");
  rsp_once_a: assert property (
    rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  hw_rst_a: assert property (
    $fell(hw_reset_n) |-> !hw_reset_n [*8])
    else $error("hardware reset pulse too short");
endmodule
`default_nettype wire

// ---- sim/bsf_flash_model.sv ----
// Purpose: behavioural boot-sector flash seen from its pins
// Assumes: host pins change only on ref_clk edges
// Notes:   unlock addresses unchecked; 64K-chunk sectors; no suspend
`timescale 1ns/1ps
`default_nettype none
module bsf_flash_model
  import bsf_pkg::*;
#(
  parameter int         BUSY_CYC  = 30,
  parameter logic [4:0] PROT_SECT = 5'h1f
)(
  input  wire logic        ref_clk,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        byte_sel,
  input  wire logic        rst_n,
  output logic [15:0]      dq_o,
  output logic             rb_n
);
  logic [15:0] mem [int];
  logic [20:0] a = 21'h0;
  logic [20:0] pa = 21'h0;
  logic [15:0] d, pd, v, m;
  logic        c, we_q = 1'b1, oe_q = 1'b1;
  int          st = 0, cnt = 0, kind = 0;
  bit          byp = 1'b0, tog = 1'b0;
  initial dq_o = 16'h0;
  initial rb_n = 1'b1;
  // ----------------------------------------
  // command decode, embedded operations, reads
  // ----------------------------------------
  always @(posedge ref_clk) begin
    m = byte_sel ? 16'h00ff : 16'hffff;
    if (!we_n) begin
      a = addr;
      d = dq;
      c = cs_n;
    end
    if (!rst_n) begin
      st = 0;
      cnt = 0;
      byp = 0;
    end else if (we_n && !we_q && !c && cnt == 0) begin
      // busy device ignores writes, so early commands are lost
      if (d[7:0] == CMD_RESET) st = 0;
      else case (st)
        0: begin
          st = (byp && d[7:0] == CMD_PROGRAM) ? 3 : (!byp && d[7:0] == UNLOCK_DATA1) ? 1 : 0;
          if (byp && d[7:0] == CMD_BYP_EXIT) byp = 0;
        end
        1: st = (d[7:0] == UNLOCK_DATA2) ? 2 : 0;
        2: begin
          byp = byp | (d[7:0] == CMD_BYPASS);
          st = (d[7:0] == CMD_PROGRAM) ? 3 : (d[7:0] == CMD_ERASE) ? 4 : 0;
        end
        3: begin
          st = 0;
          pa = a;
          pd = d & m;
          kind = 1;
          cnt = BUSY_CYC;
        end
        4: st = (d[7:0] == UNLOCK_DATA1) ? 5 : 0;
        5: st = (d[7:0] == UNLOCK_DATA2) ? 6 : 0;
        default: begin
          st = 0;
          pa = a;
          pd = 16'hffff;
          kind = (d[7:0] == CMD_CHIP) ? 3 : 2;
          cnt = (d[7:0] == CMD_CHIP || d[7:0] == CMD_SECTOR) ? BUSY_CYC : 0;
        end
      endcase
    end else if (cnt == 1) begin
      // protected sectors finish the operation unchanged
      if (kind == 1 && pa[20:16] != PROT_SECT)
        mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hffff) & pd;
      foreach (mem[k])
        if (kind > 1 && k[20:16] != PROT_SECT && (kind == 3 || k[20:16] == pa[20:16]))
          mem[k] = 16'hffff;
      cnt = 0;
    end else if (cnt > 1) cnt = cnt - 1;
    if (!oe_n && !cs_n)
      v = (cnt != 0) ? {8'h00, ~pd[7], tog, 6'h00} : (mem.exists(addr) ? mem[addr] : 16'hffff) & m;
    else v = ~dq_o; // released bus must not look like held data
    if (oe_n && !oe_q && cnt != 0) tog = ~tog;
    dq_o <= v;
    rb_n <= (cnt == 0);
    we_q = we_n;
    oe_q = oe_n;
  end
endmodule
`default_nettype wire

// ---- sim/bsf_host_bench.sv ----
// Purpose: self-checking bench for bsf_host against the flash model
// Assumes: model busy time well inside the shortened poll limit
// Notes:   suspend left out, the host is not ready during an erase
`timescale 1ns/1ps
`default_nettype none
module bsf_host_bench;
  import bsf_pkg::*;
  logic        ref_clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, word_mode = 1'b1;
  bsf_op_t     op_code = BSF_OP_READ;
  logic [20:0] op_addr = 21'h0, addr_o;
  logic [15:0] op_wdata = 16'h0, rsp_rdata, data_pins_o, data_pins_oe, fl_dq;
  logic        op_ready, rsp_valid, rsp_error, bypass_active, erase_suspended, ready_busy_n_pin;
  logic        chip_sel_n, write_strb_n, out_strb_n, word_mode_n, hw_reset_n;
  wire logic [15:0] data_pins_i;
  logic [15:0] ref_mem [int];
  logic [20:0] used [$];
  logic [31:0] seed = 32'h00013b02, r;
  int          n_errors = 0, n_compared = 0, n_wr = 0, w0;
  // ----------------------------------------
  // clock, pins, design and flash
  // ----------------------------------------
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge write_strb_n) n_wr++;
  assign data_pins_i = (data_pins_oe & data_pins_o) | (~data_pins_oe & fl_dq);
  bsf_host #(.POLL_LIMIT(20)) bsf_host_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_addr(op_addr), .op_wdata(op_wdata), .word_mode(word_mode),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
    .bypass_active(bypass_active), .erase_suspended(erase_suspended), .addr_o(addr_o),
    .data_pins_i(data_pins_i), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
    .chip_sel_n(chip_sel_n), .write_strb_n(write_strb_n), .out_strb_n(out_strb_n),
    .word_mode_n(word_mode_n), .hw_reset_n(hw_reset_n), .ready_busy_n_pin(ready_busy_n_pin));
  bsf_flash_model bsf_flash_model_i (
    .ref_clk(ref_clk), .addr(addr_o), .dq(data_pins_i), .cs_n(chip_sel_n),
    .we_n(write_strb_n), .oe_n(out_strb_n), .byte_sel(word_mode_n), .rst_n(hw_reset_n),
    .dq_o(fl_dq), .rb_n(ready_busy_n_pin));
  // ----------------------------------------
  // helpers and reference model
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_sim();
    $display("counts: compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until taken, then wait a bounded time for the answer
  task automatic op(input bsf_op_t c, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    op_code = c;
    op_addr = a;
    op_wdata = d;
    op_valid = 1'b1;
    while (op_ready !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    op_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 5000) begin
      n_errors++;
      $display("unexpected %0t no response", $time);
    end
  endtask
  task automatic rd_chk(input logic [20:0] a);
    op(BSF_OP_READ, a, 16'h0);
    chk(rsp_rdata, (ref_mem.exists(a) ? ref_mem[a] : 16'hffff)
        & (word_mode ? 16'hffff : 16'h00ff));
  endtask
  task automatic prog(input logic [20:0] a, input logic [15:0] d);
    w0 = n_wr;
    op(BSF_OP_PROGRAM, a, d);
    chk(16'(n_wr - w0), bypass_active ? 16'h2 : 16'h4);
    chk({15'h0, rsp_error}, {15'h0, a[20:16] == 5'h1f});
    if (a[20:16] != 5'h1f)
      ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] : 16'hffff) & d
                   & (word_mode ? 16'hffff : 16'h00ff);
    used.push_back(a);
  endtask
  task automatic erase(input bit chip, input logic [20:0] a);
    w0 = n_wr;
    op(chip ? BSF_OP_CHIP_ERASE : BSF_OP_SECTOR_ERASE, a, 16'h0);
    chk(16'(n_wr - w0), 16'h6);
    foreach (ref_mem[k])
      if (k[20:16] != 5'h1f && (chip || k[20:16] == a[20:16])) ref_mem[k] = 16'hffff;
    foreach (used[i]) rd_chk(used[i]);
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    chk({15'h0, op_ready}, 16'h1);
    chk({13'h0, chip_sel_n, write_strb_n, out_strb_n}, 16'h7);
    for (int i = 0; i < 3; i++) begin
      r = xs();
      prog({1'b0, r[19:0]}, r[31:16]);
    end
    foreach (used[i]) rd_chk(used[i]);
    $display("test word program done");
    op(BSF_OP_BYPASS_ENTER, 21'h0, 16'h0);
    chk({15'h0, bypass_active}, 16'h1);
    for (int i = 0; i < 2; i++) begin
      r = xs();
      prog({1'b0, r[19:0]}, r[31:16]);
    end
    op(BSF_OP_BYPASS_EXIT, 21'h0, 16'h0);
    chk({15'h0, bypass_active}, 16'h0);
    w0 = n_wr;
    op(BSF_OP_RESET_CMD, 21'h0, 16'h0);
    chk(16'(n_wr - w0), 16'h1);
    foreach (used[i]) rd_chk(used[i]);
    $display("test bypass done");
    prog({5'h1f, 16'h0010}, 16'h1234);
    rd_chk({5'h1f, 16'h0010});
    erase(1'b0, used[0]);
    $display("test protect and sector erase done");
    erase(1'b1, 21'h0);
    word_mode = 1'b0;
    r = xs();
    prog({1'b0, r[19:0]}, r[31:16]);
    rd_chk({1'b0, r[19:0]});
    word_mode = 1'b1;
    $display("test chip erase and byte mode done");
    op(BSF_OP_BYPASS_ENTER, 21'h0, 16'h0);
    op(BSF_OP_HW_RESET, 21'h0, 16'h0);
    chk({15'h0, bypass_active}, 16'h0);
    r = xs();
    prog({1'b0, r[19:0]}, r[31:16]);
    rd_chk({1'b0, r[19:0]});
    op(BSF_OP_STANDBY, 21'h0, 16'h0);
    chk({15'h0, chip_sel_n}, 16'h1);
    $display("test reset and standby done");
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    $display("unexpected %0t watchdog expired", $time);
    end_sim();
  end
endmodule
bind bsf_host bsf_host_props bsf_host_props_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid), .op_ready(op_ready),
  .word_mode(word_mode), .rsp_valid(rsp_valid), .addr_o(addr_o), .data_pins_o(data_pins_o),
  .data_pins_oe(data_pins_oe), .chip_sel_n(chip_sel_n), .write_strb_n(write_strb_n),
  .out_strb_n(out_strb_n), .word_mode_n(word_mode_n), .hw_reset_n(hw_reset_n));
`default_nettype wire
